// ---- hdl/sptc_timer.sv ----
// Secondary 16-bit compare timer with prescaler, trigger start and state bit
// How it works
// - Input select 00: count clock from module clock via prescaler, plus /256 with extra prescale.
// - Clock select 000..111 divides by 1..128; extra prescale multiplies by 256.
// - Prescaler held cleared while the run bit is zero.
// - Input select 01: one step per software count event write.
// - Input select 10: one step per rising edge of external input.
// - Input select 11: one step per falling edge of external input.
// - A period lasts period value plus one count clocks.
// - Counter counts up and clears on the count clock after period match.
// - Single shot clears the run bit when the period finishes.
// - Selected primary timer event sets the run bit.
// - Trigger select picks none, a channel compare, any, period, zero-up, Hall.
// - Trigger direction gates by primary count direction, none, up, down or both.
// - Compare match whenever counter equals active compare value.
// - Active compare loads only from shadow on shadow transfer.
// - Compare event raised on each count clock that meets a match, regardless of state bit.
// - Hardware changes state bit only while running.
// - State bit set on count clock after compare match.
// - Zero match with compare match sets state bit next count clock.
// - Zero match without compare match clears state bit next count clock.
// - Software force set and clear of state bit.
// - Counter writes ignored while running, immediate while stopped.
// - Shadow transfer while stopped, or on period match with enable; enable clears.
// - Set and clear written together leave the bit unchanged.
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "sptc_consts.svh"
module sptc_timer #(
    parameter int CLKDIV_W = 3
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic external_count_input_i,
    input wire logic primary_compare_ch0_i,
    input wire logic primary_compare_ch1_i,
    input wire logic primary_compare_ch2_i,
    input wire logic primary_period_match_i,
    input wire logic primary_zero_match_i,
    input wire logic primary_count_direction_i,
    input wire logic hall_change_i,
    output logic compare_match_event_o,
    output logic compare_state_bit_o,
    output logic period_match_signal_o,
    output logic zero_match_signal_o,
    output logic shadow_transfer_signal_o,
    output logic run_bit_o
);
    import sptc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [CLKDIV_W-1:0] clock_division_select, next_clock_division_select;
    logic extra_prescale_enable, next_extra_prescale_enable;
    logic single_shot_control, next_single_shot_control;
    sptc_isel_t count_input_select, next_count_input_select;
    logic [2:0] trigger_event_select, next_trigger_event_select;
    logic [1:0] trigger_direction_select, next_trigger_direction_select;
    logic run_bit, next_run_bit;
    logic shadow_transfer_enable, next_shadow_transfer_enable;
    sptc_word_t counter, next_counter;
    sptc_word_t active_period_register, next_active_period_register;
    sptc_word_t shadow_period, next_shadow_period;
    sptc_word_t active_compare_register, next_active_compare_register;
    sptc_word_t shadow_compare_register, next_shadow_compare_register;
    logic compare_state_bit, next_compare_state_bit;
    logic [14:0] prescale_cnt, next_prescale_cnt;
    logic ext_q, next_ext_q;
    logic [15:0] next_rdata;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Division factor minus one, as a mask on the prescale counter
    function automatic logic [14:0] div_mask(input logic [2:0] sel, input logic pre);
        logic [15:0] f;
        f = 16'h0001 << sel;
        if (pre)
        begin
            f = f << `SPTC_EXTRA_PRESCALE_SHIFT;
        end
        div_mask = 15'(f - 16'h0001);
    endfunction : div_mask

    logic wr_ctrl, wr_act, wr_mod;
    logic tick, period_match, zero_match, cmp_match, trig_event, dir_ok, st_now;
    assign wr_ctrl = reg_wr_i && reg_addr_i == `SPTC_OFS_CTRL;
    assign wr_act = reg_wr_i && reg_addr_i == `SPTC_OFS_ACTION;
    assign wr_mod = reg_wr_i && reg_addr_i == `SPTC_OFS_MODIFY;

    // Comparators on the live counter
    assign period_match = counter == active_period_register;
    assign zero_match = counter == `SPTC_RST_WORD;
    assign cmp_match = counter == active_compare_register;

    // ------------------------------------------------------------------
    // Count clock selection
    // ------------------------------------------------------------------
    always_comb
    begin
        tick = 1'b0;
        unique case (count_input_select)
            SPTC_IN_TIMER: tick = run_bit &&
                (prescale_cnt == div_mask(clock_division_select, extra_prescale_enable));
            SPTC_IN_SOFT: tick = run_bit && wr_act && reg_wdata_i[`SPTC_ACT_COUNT_BIT];
            SPTC_IN_RISE: tick = run_bit && external_count_input_i && !ext_q;
            SPTC_IN_FALL: tick = run_bit && !external_count_input_i && ext_q;
        endcase
    end

    // Trigger decode: event select then direction qualifier
    always_comb
    begin
        unique case (trigger_event_select)
            3'h0: trig_event = 1'b0;
            3'h1: trig_event = primary_compare_ch0_i;
            3'h2: trig_event = primary_compare_ch1_i;
            3'h3: trig_event = primary_compare_ch2_i;
            3'h4: trig_event = primary_compare_ch0_i | primary_compare_ch1_i |
                primary_compare_ch2_i;
            3'h5: trig_event = primary_period_match_i;
            3'h6: trig_event = primary_zero_match_i && !primary_count_direction_i;
            3'h7: trig_event = hall_change_i;
        endcase
        unique case (trigger_direction_select)
            2'h0: dir_ok = 1'b0;
            2'h1: dir_ok = !primary_count_direction_i;
            2'h2: dir_ok = primary_count_direction_i;
            2'h3: dir_ok = 1'b1;
        endcase
    end

    // Shadow transfer: always while stopped, else on period match with enable
    assign st_now = !run_bit || (shadow_transfer_enable && period_match && tick);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_clock_division_select = clock_division_select;
        next_extra_prescale_enable = extra_prescale_enable;
        next_single_shot_control = single_shot_control;
        next_count_input_select = count_input_select;
        next_trigger_event_select = trigger_event_select;
        next_trigger_direction_select = trigger_direction_select;
        next_run_bit = run_bit;
        next_shadow_transfer_enable = shadow_transfer_enable;
        next_counter = counter;
        next_active_period_register = active_period_register;
        next_shadow_period = shadow_period;
        next_active_compare_register = active_compare_register;
        next_shadow_compare_register = shadow_compare_register;
        next_compare_state_bit = compare_state_bit;
        next_ext_q = external_count_input_i;
        if (wr_ctrl)
        begin
            next_clock_division_select = reg_wdata_i[`SPTC_CTRL_CLKDIV_LSB +: CLKDIV_W];
            next_extra_prescale_enable = reg_wdata_i[`SPTC_CTRL_PRE_BIT];
            next_single_shot_control = reg_wdata_i[`SPTC_CTRL_SSC_BIT];
            next_count_input_select = sptc_isel_t'(reg_wdata_i[`SPTC_CTRL_ISEL_LSB +: 2]);
            next_trigger_event_select = reg_wdata_i[`SPTC_CTRL_TEC_LSB +: 3];
            next_trigger_direction_select = reg_wdata_i[`SPTC_CTRL_TED_LSB +: 2];
        end
        if (reg_wr_i && reg_addr_i == `SPTC_OFS_PERIOD)
        begin
            next_shadow_period = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `SPTC_OFS_SHADOW_CMP)
        begin
            next_shadow_compare_register = reg_wdata_i;
        end
        // Counter writes only land while stopped
        if (reg_wr_i && reg_addr_i == `SPTC_OFS_COUNTER && !run_bit)
        begin
            next_counter = reg_wdata_i;
        end
        // Period match wraps to zero, otherwise count up
        if (tick)
        begin
            next_counter = period_match ? `SPTC_RST_WORD : 16'(counter + 16'h0001);
        end
        // Counter reset action does not touch the run bit
        if (wr_act && reg_wdata_i[`SPTC_ACT_RESET_BIT])
        begin
            next_counter = `SPTC_RST_WORD;
        end
        // State bit switching, only with a count clock while running
        if (tick)
        begin
            if (zero_match)
            begin
                next_compare_state_bit = cmp_match;
            end
            else if (cmp_match)
            begin
                next_compare_state_bit = 1'b1;
            end
        end
        if (wr_mod && (reg_wdata_i[`SPTC_MOD_SET_BIT] ^ reg_wdata_i[`SPTC_MOD_CLR_BIT]))
        begin
            next_compare_state_bit = reg_wdata_i[`SPTC_MOD_SET_BIT];
        end
        // Run bit: single shot stop, then software, trigger start last
        if (tick && period_match && single_shot_control)
        begin
            next_run_bit = 1'b0;
        end
        if (wr_act && (reg_wdata_i[`SPTC_ACT_RUN_SET_BIT] ^ reg_wdata_i[`SPTC_ACT_RUN_CLR_BIT]))
        begin
            next_run_bit = reg_wdata_i[`SPTC_ACT_RUN_SET_BIT];
        end
        if (trig_event && dir_ok)
        begin
            next_run_bit = 1'b1;
        end
        // Shadow transfer moves period and compare, then drops the enable
        if (st_now)
        begin
            next_active_period_register = shadow_period;
            next_active_compare_register = shadow_compare_register;
            next_shadow_transfer_enable = 1'b0;
        end
        if (wr_act && (reg_wdata_i[`SPTC_ACT_STE_SET_BIT] ^ reg_wdata_i[`SPTC_ACT_STE_CLR_BIT]))
        begin
            next_shadow_transfer_enable = reg_wdata_i[`SPTC_ACT_STE_SET_BIT];
        end
    end

    // Prescaler cleared while stopped so the first tick after start is fixed
    always_comb
    begin
        if (!run_bit || tick)
        begin
            next_prescale_cnt = 15'h0000;
        end
        else
        begin
            next_prescale_cnt = 15'(prescale_cnt + 15'h0001);
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        next_rdata = 16'h0000;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `SPTC_OFS_CTRL: next_rdata = {4'h0, trigger_direction_select,
                    trigger_event_select, count_input_select, single_shot_control,
                    extra_prescale_enable, clock_division_select};
                `SPTC_OFS_COUNTER: next_rdata = counter;
                `SPTC_OFS_PERIOD: next_rdata = active_period_register;
                `SPTC_OFS_SHADOW_CMP: next_rdata = shadow_compare_register;
                `SPTC_OFS_ACTIVE_CMP: next_rdata = active_compare_register;
                `SPTC_OFS_STATUS: next_rdata = {13'h0000, shadow_transfer_enable,
                    run_bit, compare_state_bit};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clock_division_select <= '0;
            extra_prescale_enable <= 1'b0;
            single_shot_control <= 1'b0;
            count_input_select <= SPTC_IN_TIMER;
            trigger_event_select <= 3'h0;
            trigger_direction_select <= 2'h0;
            run_bit <= 1'b0;
            shadow_transfer_enable <= 1'b0;
            counter <= `SPTC_RST_WORD;
            active_period_register <= `SPTC_RST_WORD;
            shadow_period <= `SPTC_RST_WORD;
            active_compare_register <= `SPTC_RST_WORD;
            shadow_compare_register <= `SPTC_RST_WORD;
            compare_state_bit <= 1'b0;
            prescale_cnt <= 15'h0000;
            ext_q <= 1'b0;
            reg_rdata_o <= 16'h0000;
            compare_match_event_o <= 1'b0;
            period_match_signal_o <= 1'b0;
            zero_match_signal_o <= 1'b0;
            shadow_transfer_signal_o <= 1'b0;
        end
        else
        begin
            clock_division_select <= next_clock_division_select;
            extra_prescale_enable <= next_extra_prescale_enable;
            single_shot_control <= next_single_shot_control;
            count_input_select <= next_count_input_select;
            trigger_event_select <= next_trigger_event_select;
            trigger_direction_select <= next_trigger_direction_select;
            run_bit <= next_run_bit;
            shadow_transfer_enable <= next_shadow_transfer_enable;
            counter <= next_counter;
            active_period_register <= next_active_period_register;
            shadow_period <= next_shadow_period;
            active_compare_register <= next_active_compare_register;
            shadow_compare_register <= next_shadow_compare_register;
            compare_state_bit <= next_compare_state_bit;
            prescale_cnt <= next_prescale_cnt;
            ext_q <= next_ext_q;
            reg_rdata_o <= next_rdata;
            compare_match_event_o <= cmp_match && tick;
            period_match_signal_o <= period_match;
            zero_match_signal_o <= zero_match;
            shadow_transfer_signal_o <= st_now;
        end
    end

    assign compare_state_bit_o = compare_state_bit;
    assign run_bit_o = run_bit;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    chk_wrap_zero: assert property (tick && period_match |=> counter == 16'h0000)
        else $error("counter did not clear after period match");
    chk_stop_prescale: assert property (!run_bit |=> prescale_cnt == 15'h0000)
        else $error("prescaler not held while stopped");
    chk_single_shot: assert property (tick && period_match && single_shot_control &&
        !trig_event && !wr_act |=> !run_bit)
        else $error("single shot did not stop");
    chk_trig_start: assert property (trig_event && dir_ok |=> run_bit)
        else $error("trigger did not start timer");
    chk_state_hold: assert property (!run_bit && !wr_mod |=> $stable(compare_state_bit))
        else $error("state bit changed while stopped");
    chk_cmp_load: assert property (!$stable(active_compare_register) |->
        $past(st_now) && active_compare_register == $past(shadow_compare_register))
        else $error("compare register loaded outside transfer");
    chk_cnt_write: assert property (reg_wr_i && reg_addr_i == `SPTC_OFS_COUNTER && run_bit &&
        !tick && !wr_act |=> $stable(counter))
        else $error("counter write landed while running");
    chk_state_zero: assert property (tick && zero_match && !cmp_match && !wr_mod
        |=> !compare_state_bit)
        else $error("state bit not cleared on zero match");
    cov_single_shot: cover property (run_bit ##1 !run_bit);
    cov_trigger: cover property (trig_event && dir_ok && !run_bit);
    cov_cmp: cover property (tick && cmp_match && !zero_match);
endmodule : sptc_timer

// ---- inc/sptc_consts.svh ----
// Constant macros for the secondary timer compare block
`ifndef SPTC_CONSTS_SVH
`define SPTC_CONSTS_SVH
// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define SPTC_OFS_CTRL 4'h0
`define SPTC_OFS_ACTION 4'h1
`define SPTC_OFS_COUNTER 4'h2
`define SPTC_OFS_PERIOD 4'h3
`define SPTC_OFS_SHADOW_CMP 4'h4
`define SPTC_OFS_ACTIVE_CMP 4'h5
`define SPTC_OFS_STATUS 4'h6
`define SPTC_OFS_MODIFY 4'h7
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SPTC_CTRL_CLKDIV_LSB 0
`define SPTC_CTRL_PRE_BIT 3
`define SPTC_CTRL_SSC_BIT 4
`define SPTC_CTRL_ISEL_LSB 5
`define SPTC_CTRL_TEC_LSB 7
`define SPTC_CTRL_TED_LSB 10
// ----------------------------------------------------------------------
// Action register fields (write only, self clearing)
// ----------------------------------------------------------------------
`define SPTC_ACT_RUN_CLR_BIT 0
`define SPTC_ACT_RUN_SET_BIT 1
`define SPTC_ACT_RESET_BIT 2
`define SPTC_ACT_COUNT_BIT 3
`define SPTC_ACT_STE_SET_BIT 4
`define SPTC_ACT_STE_CLR_BIT 5
// ----------------------------------------------------------------------
// Status and modify register fields
// ----------------------------------------------------------------------
`define SPTC_STAT_STATE_BIT 0
`define SPTC_STAT_RUN_BIT 1
`define SPTC_STAT_STE_BIT 2
`define SPTC_MOD_SET_BIT 0
`define SPTC_MOD_CLR_BIT 1
// ----------------------------------------------------------------------
// Reset values and prescale
// ----------------------------------------------------------------------
`define SPTC_RST_WORD 16'h0000
`define SPTC_EXTRA_PRESCALE_SHIFT 8
`endif

// ---- inc/sptc_pkg.sv ----
// Types shared by the secondary timer compare block
package sptc_pkg;
    typedef enum logic [1:0] {
        SPTC_IN_TIMER,
        SPTC_IN_SOFT,
        SPTC_IN_RISE,
        SPTC_IN_FALL
    } sptc_isel_t;
    typedef logic [15:0] sptc_word_t;
endpackage : sptc_pkg

// ---- tb/sptc_primary_model.sv ----
// Behavioural model of the primary timer event outputs
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Primary timer events
// ----------------------------------------------------------------------
module sptc_primary_model (
    input wire logic core_clk_i,
    input wire logic fire_i,
    input wire logic [2:0] ev_i,
    input wire logic dir_i,
    output logic [5:0] ev_o,
    output logic dir_o
);
    // One-hot single-cycle pulse; direction registered on the same clock
    always_ff @(posedge core_clk_i)
    begin
        ev_o <= fire_i ? (6'h01 << ev_i) : 6'h00;
        dir_o <= dir_i;
    end
endmodule : sptc_primary_model

// ---- tb/tb_sptc_timer.sv ----
// Self-checking bench for the secondary compare timer
`timescale 1ns/1ps
`define CHK(n, e, s) check_val(n, 16'(e), 16'(s));
module tb_sptc_timer;
    import sptc_pkg::*;
    logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, ext_i, fire, dir, pdir;
    logic cme, cst, pms, zms, sts, run;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, rdata, rd_v;
    logic [2:0] ev;
    logic [5:0] pev;
    logic [31:0] seed;
    int failures, n_checks, cycles, cm_cnt;
    int ev_map[8] = '{0, 0, 1, 2, 1, 3, 4, 5};
    int mods[4] = '{1, 3, 2, 3};
    int mexp[4] = '{1, 1, 0, 0};
    // ------------------------------------------------------------------
    // Design and far side
    // ------------------------------------------------------------------
    sptc_timer #(.CLKDIV_W(3)) dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata), .external_count_input_i(ext_i),
        .primary_compare_ch0_i(pev[0]), .primary_compare_ch1_i(pev[1]),
        .primary_compare_ch2_i(pev[2]), .primary_period_match_i(pev[3]),
        .primary_zero_match_i(pev[4]), .primary_count_direction_i(pdir),
        .hall_change_i(pev[5]), .compare_match_event_o(cme), .compare_state_bit_o(cst),
        .period_match_signal_o(pms), .zero_match_signal_o(zms),
        .shadow_transfer_signal_o(sts), .run_bit_o(run));
    sptc_primary_model pm_u (.core_clk_i(core_clk_i), .fire_i(fire), .ev_i(ev),
        .dir_i(dir), .ev_o(pev), .dir_o(pdir));
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Clock at 40 MHz
    initial
    begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Hang guard and compare event counter
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cme === 1'b1) cm_cnt++;
        if (cycles == 20000)
        begin
            failures++;
            test_done();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] ctrl(int sel, int pre, int ssc, int isel, int tec, int ted);
        return {4'h0, 2'(ted), 3'(tec), 2'(isel), 1'(ssc), 1'(pre), 3'(sel)};
    endfunction : ctrl
    // Start expected from the selected primary event and its direction gate
    function automatic logic exp_trig(int tec, int ted, int e, logic d);
        logic hit;
        hit = (tec >= 1 && tec <= 3 && e == tec - 1) || (tec == 4 && e < 3) ||
            (tec == 5 && e == 3) || (tec == 6 && e == 4 && !d) || (tec == 7 && e == 5);
        return hit && (ted == 3 || (ted == 1 && !d) || (ted == 2 && d));
    endfunction : exp_trig
    task automatic check_val(input string n, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check_val
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 rd_v = rdata;
    endtask : rd
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        int p, c, k, nm, cm0, n, v0, d, e;
        seed = 32'h0000_0049;
        {rst_b_i, reg_wr_i, reg_rd_i, ext_i, fire, dir, ev} = '0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        repeat (2) @(posedge core_clk_i);
        rst_b_i <= 1'b1;
        for (int a = 0; a < 16; a++) if (a != 1 && a != 7)
        begin
            rd(4'(a));
            `CHK("reset read", 0, rd_v)
        end
        `CHK("transfer while stopped", 1, sts)
        // Software counting through several periods, random period and compare
        p = 2 + int'(rnd() % 8);
        c = 1 + int'(rnd() % (p - 1));
        wr(4'h3, 16'(p));
        wr(4'h4, 16'(c));
        wr(4'h0, ctrl(0, 0, 0, 1, 0, 0));
        rd(4'h5);
        `CHK("active compare", c, rd_v)
        wr(4'h1, 16'h0002);
        wr(4'h2, 16'h0007);
        rd(4'h2);
        `CHK("count write while running", 0, rd_v)
        k = 0;
        nm = 0;
        cm0 = cm_cnt;
        repeat (3 * (p + 1))
        begin
            if (k % (p + 1) == c) nm++;
            wr(4'h1, 16'h0008);
            k++;
            rd(4'h2);
            `CHK("soft count", k % (p + 1), rd_v)
            `CHK("state bit", (k % (p + 1) > c) || (k % (p + 1) == 0), cst)
            `CHK("zero match", k % (p + 1) == 0, zms)
            `CHK("period match", k % (p + 1) == p, pms)
        end
        `CHK("compare events", nm, cm_cnt - cm0)
        // Shadow compare waits for the period match once enabled
        wr(4'h4, 16'h0001);
        rd(4'h5);
        `CHK("no early load", c, rd_v)
        `CHK("no transfer while running", 0, sts)
        wr(4'h1, 16'h0010);
        repeat (p + 1) wr(4'h1, 16'h0008);
        rd(4'h5);
        `CHK("load on period", 1, rd_v)
        rd(4'h6);
        `CHK("enable self clears", 0, rd_v[2])
        // Software force of the state bit while stopped
        wr(4'h1, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            wr(4'h7, 16'(mods[i]));
            #1 `CHK("forced state", mexp[i], cst)
        end
        // Single shot stops at the end of one period
        wr(4'h0, ctrl(0, 0, 1, 1, 0, 0));
        wr(4'h1, 16'h0006);
        repeat (p) wr(4'h1, 16'h0008);
        #1 `CHK("still running", 1, run)
        wr(4'h1, 16'h0008);
        #1 `CHK("single shot stop", 0, run)
        // Zero match that is also a compare match sets a cleared state bit
        wr(4'h7, 16'h0002);
        wr(4'h4, 16'h0000);
        wr(4'h0, ctrl(0, 0, 0, 1, 0, 0));
        wr(4'h1, 16'h0006);
        wr(4'h1, 16'h0008);
        #1 `CHK("zero and compare", 1, cst)
        // External edges: n rises and n-1 falls tell the two modes apart
        for (int isel = 2; isel < 4; isel++)
        begin
            n = 1 + int'(rnd() % p);
            ext_i <= 1'b0;
            wr(4'h0, ctrl(0, 0, 0, isel, 0, 0));
            wr(4'h1, 16'h0006);
            for (int j = 0; j < 2 * n - 1; j++)
            begin
                ext_i <= (j % 2 == 0);
                repeat (3) @(posedge core_clk_i);
            end
            rd(4'h2);
            `CHK("edge count", isel == 2 ? n : n - 1, rd_v)
            wr(4'h1, 16'h0001);
        end
        ext_i <= 1'b0;
        // Timer mode: eight ticks' worth of cycles, twice for reproducibility
        wr(4'h3, 16'hFFFF);
        for (int i = 0; i < 5; i++)
        begin
            d = (i < 4) ? (1 << i) : 256;
            wr(4'h0, ctrl(i < 4 ? i : 0, i == 4, 0, 0, 0, 0));
            for (int r = 0; r < 2; r++)
            begin
                wr(4'h1, 16'h0006);
                repeat (8 * d) @(posedge core_clk_i);
                wr(4'h1, 16'h0001);
                rd(4'h2);
                if (r == 0) v0 = int'(rd_v);
                `CHK("tick rate", (8 * d + 2) / d, rd_v)
                `CHK("same after restart", v0, rd_v)
            end
        end
        // Trigger start over every event select and direction code
        for (int tec = 0; tec < 8; tec++)
            for (int ted = 0; ted < 4; ted++)
            begin
                wr(4'h1, 16'h0005);
                wr(4'h0, ctrl(0, 0, 0, 1, tec, ted));
                e = rnd() % 2 ? ev_map[tec] : int'(rnd() % 6);
                dir <= 1'(rnd() % 2);
                ev <= 3'(e);
                @(posedge core_clk_i);
                fire <= 1'b1;
                @(posedge core_clk_i);
                fire <= 1'b0;
                repeat (3) @(posedge core_clk_i);
                `CHK("trigger start", exp_trig(tec, ted, e, dir), run)
            end
        test_done();
    end
endmodule : tb_sptc_timer
